// ---- dpram_host_pkg.sv ----
package dpram_host_pkg;
	// ************************************************************
	// geometry
	// ************************************************************
	localparam int ADDR_W       = 14;
	localparam int DATA_W       = 8;
	localparam int FLAG_ADDR_W  = 3;
	localparam logic [13:0] MAILBOX_TO_RIGHT = 14'h3FFF;
	localparam logic [13:0] MAILBOX_TO_LEFT  = 14'h3FFE;
	localparam int LSB_POS      = 0;
	// ************************************************************
	// timing, in ns, and derived cycle counts at 20 MHz
	// ************************************************************
	localparam int CLK_NS                  = 50;
	localparam int SELECT_TO_WRITE_END_NS  = 15;
	localparam int FLAG_UPDATE_PULSE_NS    = 10;
	localparam int WRITE_HOLD_AFTER_REL_NS = 15;
	localparam int READ_ACCESS_NS          = 20;
	localparam int RECOVERY_NS             = 20;
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int WRITE_CYC   = cyc_min(SELECT_TO_WRITE_END_NS);
	localparam int PULSE_CYC   = cyc_min(FLAG_UPDATE_PULSE_NS);
	localparam int HOLD_CYC    = cyc_min(WRITE_HOLD_AFTER_REL_NS);
	localparam int READ_CYC    = cyc_min(READ_ACCESS_NS) + 1;
	localparam int RECOVER_CYC = cyc_min(RECOVERY_NS);
	localparam int CNT_W       = 4;
	// ************************************************************
	// request kinds
	// ************************************************************
	typedef enum logic [1:0] {
		OP_RAM_READ,
		OP_RAM_WRITE,
		OP_FLAG_READ,
		OP_FLAG_WRITE
	} op_e;
endpackage

// ---- pulse_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
// down counter giving a one-cycle done pulse after a load
module pulse_timer
	import dpram_host_pkg::*;
(
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] count,
	input  wire logic             hold,
	output logic                  done
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic             run_q, run_d;
	logic             done_q, done_d;

	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		if (load) begin
			cnt_d = count;
			run_d = 1'b1;
		end else if (run_q && !hold) begin
			if (cnt_q <= 4'h1) begin
				run_d  = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 4'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_q  <= 4'h0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule // pulse_timer
`default_nettype wire

// ---- dpram_port_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - memory needs select low, flag select high; flags the reverse; held throughout.
// - read-not-write stays high for the whole of every read.
// - address changes only while read-not-write or chip select is high.
// - host never drives data while device may still drive the pins.
// - semaphore reads need a fresh select pulse of the minimum update width.
// - as slave, hold write asserted the set interval after busy rises.
module dpram_port_host
	import dpram_host_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              req_valid,
	input  wire op_e               req_op,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic              slave_mode,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	output logic                   rsp_flag_won,
	output logic [ADDR_W-1:0]      addr,
	output logic                   chip_select_n,
	output logic                   flag_lock_select_n,
	output logic                   read_not_write,
	output logic                   output_enable_n,
	output logic [DATA_W-1:0]      data_o,
	output logic                   data_oe_n,
	input  wire logic [DATA_W-1:0] data_i,
	input  wire logic              busy_n
);
	// ************************************************************
	// sequencer
	// ************************************************************
	typedef enum logic [2:0] {IDLE, SETUP, READ, WRITE, HOLD, RECOVER} state_e;
	state_e            state_q, state_d;
	op_e               op_q, op_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic              cs_n_q, cs_n_d, fs_n_q, fs_n_d, rnw_q, rnw_d, oe_n_q, oe_n_d;
	logic              doe_n_q, doe_n_d, ready_q, ready_d, rv_q, rv_d, won_q, won_d;
	logic              t_load;
	logic [CNT_W-1:0]  t_count;
	logic              t_done;

	function automatic logic is_write(input op_e o);
		return (o == OP_RAM_WRITE) || (o == OP_FLAG_WRITE);
	endfunction
	function automatic logic is_flag(input op_e o);
		return (o == OP_FLAG_READ) || (o == OP_FLAG_WRITE);
	endfunction

	pulse_timer u_timer (
		.clock (clock),
		.reset (reset),
		.load  (t_load),
		.count (t_count),
		// slave busy stretches the write until busy is released
		.hold  (state_q == WRITE && slave_mode && !busy_n),
		.done  (t_done)
	);

	always_comb begin
		state_d = state_q;
		op_d    = op_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		cs_n_d  = cs_n_q;
		fs_n_d  = fs_n_q;
		rnw_d   = rnw_q;
		oe_n_d  = oe_n_q;
		doe_n_d = doe_n_q;
		ready_d = 1'b0;
		rv_d    = 1'b0;
		won_d   = won_q;
		t_load  = 1'b0;
		t_count = 4'h0;
		unique case (state_q)
			IDLE: begin
				ready_d = 1'b1;
				if (req_valid && ready_q) begin
					// address moves only with both strobes high
					op_d    = req_op;
					addr_d  = is_flag(req_op) ? {{(ADDR_W-FLAG_ADDR_W){1'b0}}, req_addr[FLAG_ADDR_W-1:0]}
						: req_addr;
					wdata_d = req_wdata;
					rnw_d   = !is_write(req_op);
					ready_d = 1'b0;
					state_d = SETUP;
				end
			end
			SETUP: begin
				// exactly one select low; never both (illegal)
				cs_n_d = is_flag(op_q);
				fs_n_d = !is_flag(op_q);
				t_load = 1'b1;
				if (is_write(op_q)) begin
					// select falls after write start: pins are ours at once
					doe_n_d = 1'b0;
					t_count = 4'(WRITE_CYC);
					state_d = WRITE;
				end else begin
					oe_n_d  = 1'b0;
					t_count = 4'(READ_CYC > PULSE_CYC ? READ_CYC : PULSE_CYC);
					state_d = READ;
				end
			end
			READ: begin
				if (t_done) begin
					// flag reads: any line carries the latched value
					rdata_d = data_i;
					won_d   = is_flag(op_q) && !data_i[LSB_POS];
					cs_n_d  = 1'b1;
					fs_n_d  = 1'b1;
					oe_n_d  = 1'b1;
					t_load  = 1'b1;
					t_count = 4'(RECOVER_CYC);
					state_d = RECOVER;
				end
			end
			WRITE: begin
				if (t_done) begin
					t_load  = 1'b1;
					t_count = 4'(HOLD_CYC);
					state_d = HOLD;
				end
			end
			HOLD: begin
				if (t_done) begin
					// write ends on select rising; data still held this cycle
					cs_n_d  = 1'b1;
					fs_n_d  = 1'b1;
					t_load  = 1'b1;
					t_count = 4'(RECOVER_CYC);
					state_d = RECOVER;
				end
			end
			RECOVER: begin
				rnw_d   = 1'b1;
				doe_n_d = 1'b1;
				if (t_done) begin
					rv_d    = 1'b1;
					state_d = IDLE;
				end
			end
			default: state_d = IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= IDLE;
			op_q    <= OP_RAM_READ;
			addr_q  <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			cs_n_q  <= 1'b1;
			fs_n_q  <= 1'b1;
			rnw_q   <= 1'b1;
			oe_n_q  <= 1'b1;
			doe_n_q <= 1'b1;
			ready_q <= 1'b0;
			rv_q    <= 1'b0;
			won_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q    <= op_d;
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			cs_n_q  <= cs_n_d;
			fs_n_q  <= fs_n_d;
			rnw_q   <= rnw_d;
			oe_n_q  <= oe_n_d;
			doe_n_q <= doe_n_d;
			ready_q <= ready_d;
			rv_q    <= rv_d;
			won_q   <= won_d;
		end
	end

	assign req_ready          = ready_q;
	assign rsp_valid          = rv_q;
	assign rsp_rdata          = rdata_q;
	assign rsp_flag_won       = won_q;
	assign addr               = addr_q;
	assign chip_select_n      = cs_n_q;
	assign flag_lock_select_n = fs_n_q;
	assign read_not_write     = rnw_q;
	assign output_enable_n    = oe_n_q;
	assign data_o             = wdata_q;
	assign data_oe_n          = doe_n_q;

	// ************************************************************
	// checks
	// ************************************************************
	both_selects_a: assert property (@(posedge clock) disable iff (reset)
		!(!chip_select_n && !flag_lock_select_n)) else $error("both selects low");
	read_rnw_high_a: assert property (@(posedge clock) disable iff (reset)
		(!output_enable_n) |-> read_not_write) else $error("read with write line low");
	addr_stable_a: assert property (@(posedge clock) disable iff (reset)
		(addr != $past(addr)) |-> (read_not_write || chip_select_n)) else $error("address moved under write");
	no_drive_read_a: assert property (@(posedge clock) disable iff (reset)
		(!output_enable_n) |-> data_oe_n) else $error("data driven during read");
	select_held_a: assert property (@(posedge clock) disable iff (reset)
		$fell(chip_select_n) |=> !chip_select_n [*2]) else $error("select dropped early");
	write_order_a: assert property (@(posedge clock) disable iff (reset)
		($fell(chip_select_n) || $fell(flag_lock_select_n)) && !read_not_write |-> !$past(read_not_write))
		else $error("select before write line");
	resp_after_a: assert property (@(posedge clock) disable iff (reset)
		$rose(chip_select_n) && !read_not_write |-> ##[1:3] rsp_valid) else $error("no write response");
	flag_pulse_a: assert property (@(posedge clock) disable iff (reset)
		$fell(flag_lock_select_n) |=> !flag_lock_select_n) else $error("flag pulse too short");
endmodule // dpram_port_host
`default_nettype wire

// ---- dpram_dev_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ********************************
// one port of the two-port memory
// ********************************
module dpram_dev_model
	import dpram_host_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              chip_select_n,
	input  wire logic              flag_lock_select_n,
	input  wire logic              read_not_write,
	input  wire logic              output_enable_n,
	input  wire logic [DATA_W-1:0] data_o,
	input  wire logic              data_oe_n,
	input  wire logic [7:0]        other_own,
	input  wire logic [ADDR_W-1:0] other_addr,
	input  wire logic              other_cs_n,
	output logic      [DATA_W-1:0] data_i,
	output logic                   busy_n,
	output logic                   mbox_right,
	output logic                   clash
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [7:0]        host_own = 8'h00;
	logic [7:0]        pend     = 8'h00;
	logic [DATA_W-1:0] flag_lat = 8'hFF;
	logic [DATA_W-1:0] last     = 8'hA5;
	logic              rd;
	assign rd = read_not_write && !output_enable_n && (chip_select_n != flag_lock_select_n);
	initial clash = 1'h0;
	initial mbox_right = 1'h0;
	// the other port is taken to win every tie, so busy only ever lands here
	assign busy_n = !(!chip_select_n && !other_cs_n && addr == other_addr);
	// data taken at the end of the overlap; both selects low is ignored
	always @(posedge chip_select_n) if (!read_not_write && flag_lock_select_n) begin
		mem[addr] = data_o;
		if (addr == MAILBOX_TO_RIGHT && busy_n) mbox_right = 1'h1;
	end
	always @(posedge flag_lock_select_n) if (!read_not_write && chip_select_n) begin
		if (data_o[LSB_POS]) begin
			host_own[addr[2:0]] = 1'h0;
			pend[addr[2:0]] = 1'h0;
		end else if (other_own[addr[2:0]]) pend[addr[2:0]] = 1'h1;
		else host_own[addr[2:0]] = 1'h1;
	end
	// a waiting claim wins the moment the other side lets go
	always @(other_own) begin
		host_own = host_own | (pend & ~other_own);
		pend = pend & other_own;
	end
	always @(negedge flag_lock_select_n) flag_lat = {8{~host_own[addr[2:0]]}};
	// released lines show the inverse so a stale value never passes
	always @* data_i = rd ? (!chip_select_n ? mem[addr] : flag_lat) : ~last;
	always @(data_i) if (rd === 1'h1) last = data_i;
	always @(rd or data_oe_n) if (rd && !data_oe_n) clash = 1'h1;
endmodule // dpram_dev_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ********************************
// bench
// ********************************
module tb;
	import dpram_host_pkg::*;
	typedef struct {logic rd; logic fl; logic [7:0] d; logic w;} note_s;
	logic        clock = 1'h0;
	logic        reset = 1'h1;
	logic        req_valid = 1'h0;
	op_e         req_op = OP_RAM_READ;
	logic [13:0] req_addr = 14'h0000;
	logic [7:0]  req_wdata = 8'h00;
	logic        slave_mode = 1'h0;
	logic        busy_n;
	logic        other_cs_n = 1'h1;
	logic [13:0] other_addr = 14'h0000;
	logic        mbox_right;
	logic [7:0]  other_own = 8'h00;
	logic        req_ready, rsp_valid, rsp_flag_won, chip_select_n, flag_lock_select_n;
	logic        read_not_write, output_enable_n, data_oe_n, clash;
	logic [7:0]  rsp_rdata, data_o, data_i;
	logic [13:0] addr;
	integer      seed = 32'h650ED6F7;
	int          n_fail = 0;
	int          cmp_count = 0;
	note_s       notes[$];
	logic [13:0] al[8];
	logic [7:0]  dl[8];
	int          k;
	always #25 clock = ~clock;
	dpram_port_host dut_u (.clock(clock), .reset(reset), .req_valid(req_valid), .req_op(req_op),
		.req_addr(req_addr), .req_wdata(req_wdata), .slave_mode(slave_mode), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_flag_won(rsp_flag_won), .addr(addr),
		.chip_select_n(chip_select_n), .flag_lock_select_n(flag_lock_select_n), .read_not_write(read_not_write),
		.output_enable_n(output_enable_n), .data_o(data_o), .data_oe_n(data_oe_n), .data_i(data_i), .busy_n(busy_n));
	dpram_dev_model dev_u (.addr(addr), .chip_select_n(chip_select_n), .flag_lock_select_n(flag_lock_select_n),
		.read_not_write(read_not_write), .output_enable_n(output_enable_n), .data_o(data_o),
		.data_oe_n(data_oe_n), .other_own(other_own), .other_addr(other_addr), .other_cs_n(other_cs_n),
		.data_i(data_i), .busy_n(busy_n), .mbox_right(mbox_right), .clash(clash));
	task automatic test_done();
		if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask
	// waits for ready, then one request; the note goes in before the take
	task automatic issue(input op_e op, input logic [13:0] a, input logic [7:0] wd, input logic [7:0] ed,
		input logic ew);
		int i;
		note_s n;
		@(negedge clock);
		for (i = 0; i < 60 && req_ready !== 1'h1; i++) @(negedge clock);
		if (i == 60) begin
			n_fail++;
			$display("unexpected at %0t: no ready", $time);
			test_done();
		end
		n.rd = (op == OP_RAM_READ || op == OP_FLAG_READ);
		n.fl = (op == OP_FLAG_READ);
		n.d = ed;
		n.w = ew;
		notes.push_back(n);
		req_op = op;
		req_addr = a;
		req_wdata = wd;
		req_valid = 1'h1;
		@(negedge clock);
		req_valid = 1'h0;
	endtask
	always @(negedge clock) if (rsp_valid === 1'h1) begin
		if (notes.size() == 0) begin
			n_fail++;
			$display("unexpected at %0t: stray response", $time);
		end else begin
			if (notes[0].rd) cmp_data(rsp_rdata, notes[0].d);
			if (notes[0].fl) cmp_bit(rsp_flag_won, notes[0].w);
			void'(notes.pop_front());
		end
	end
	initial begin
		repeat (20) @(negedge clock);
		reset = 1'h0;
		for (k = 0; k < 8; k++) begin
			// distinct words, never a mailbox word
			al[k] = {1'h0, 10'($random(seed)), 3'(k)};
			dl[k] = 8'($random(seed));
			issue(OP_RAM_WRITE, al[k], dl[k], 8'h00, 1'h0);
		end
		for (k = 7; k >= 0; k--) issue(OP_RAM_READ, al[k], 8'h00, dl[k], 1'h0);
		for (k = 0; k < 8; k++) issue(OP_FLAG_READ, 14'(k), 8'h00, 8'hFF, 1'h0);
		issue(OP_FLAG_WRITE, 14'h0002, 8'hFE, 8'h00, 1'h0);
		issue(OP_FLAG_READ, 14'h3FFA, 8'h00, 8'h00, 1'h1);
		issue(OP_FLAG_WRITE, 14'h0002, 8'h01, 8'h00, 1'h0);
		issue(OP_FLAG_READ, 14'h0002, 8'h00, 8'hFF, 1'h0);
		other_own = 8'h08;
		issue(OP_FLAG_WRITE, 14'h0003, 8'h00, 8'h00, 1'h0);
		issue(OP_FLAG_READ, 14'h0003, 8'h00, 8'hFF, 1'h0);
		issue(OP_RAM_READ, al[0], 8'h00, dl[0], 1'h0);
		other_own = 8'h00;
		issue(OP_FLAG_READ, 14'h0003, 8'h00, 8'h00, 1'h1);
		cmp_bit(mbox_right, 1'h0);
		// slave role: the other port sits on the same word, so busy stalls the write
		slave_mode = 1'h1;
		other_addr = al[1];
		other_cs_n = 1'h0;
		issue(OP_RAM_WRITE, al[1], 8'h5A, 8'h00, 1'h0);
		repeat (12) @(negedge clock);
		cmp_bit(notes.size() == 1, 1'h1);
		cmp_bit(chip_select_n, 1'h0);
		cmp_bit(busy_n, 1'h0);
		other_addr = al[2];
		issue(OP_RAM_READ, al[1], 8'h00, 8'h5A, 1'h0);
		cmp_bit(busy_n, 1'h1);
		other_cs_n = 1'h1;
		slave_mode = 1'h0;
		issue(OP_RAM_WRITE, MAILBOX_TO_RIGHT, 8'h3C, 8'h00, 1'h0);
		for (k = 0; k < 100 && notes.size() > 0; k++) @(negedge clock);
		cmp_bit(notes.size() == 0, 1'h1);
		cmp_bit(mbox_right, 1'h1);
		cmp_bit(clash, 1'h0);
		test_done();
	end
endmodule // tb
`default_nettype wire
